// File: core/spc_pkg.sv
package spc_pkg;
  // ********
  // Timing
  // ********
  localparam int CLK_NS = 100;
  localparam int SCLK_HALF_NS = 400;
  // Least time, so round up
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_BITS = 8;
  // ********
  // Register map
  // ********
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int B_SERIAL_PORT_ON = 0;
  localparam int B_MASTER_ROLE = 1;
  localparam int B_CLOCK_PHASE = 2;
  localparam int B_CLOCK_POLARITY = 3;
  localparam int B_WIRED_OR = 4;
  localparam int B_LSB_FIRST = 5;
  localparam int B_TRIGGER_MODE = 6;
  localparam int B_ZERO_FILL = 7;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_IMPL = 16'h00ff;
  localparam int IRQ_W = 2;
  localparam int I_TXE = 0;
  localparam int I_RXF = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam int ST_TXCNT = 0;
  localparam int ST_RXCNT = 4;
  localparam int ST_BUSY = 8;
  localparam int ST_PEND = 9;

  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_RUN = 3'b010,
    SPC_GAP = 3'b100
  } spc_state_e;

  function automatic logic spc_out_bit(input logic [7:0] d, input logic lsb);
    return lsb ? d[0] : d[7];
  endfunction

  function automatic logic [7:0] spc_shift_out(input logic [7:0] d, input logic lsb);
    return lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] spc_shift_in(input logic [7:0] d, input logic b,
                                              input logic lsb);
    return lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  function automatic logic spc_mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_TXDATA || a == OFS_RXDATA || a == OFS_STATUS
        || a == OFS_IRQ_ST || a == OFS_IRQ_MASK;
  endfunction
endpackage

// File: core/spc_link_if.sv
`timescale 1ns/1ps
interface spc_link_if;
  logic serial_port_on;
  logic master_role_select;
  logic clock_phase;
  logic clock_polarity;
  logic wired_or_output;
  logic lsb_first_select;
  logic start;
  logic [7:0] tx_byte;
  logic take;
  logic done;
  logic busy;
  logic [7:0] rx_byte;
  modport ctl (output serial_port_on, master_role_select, clock_phase, clock_polarity,
               wired_or_output, lsb_first_select, start, tx_byte,
               input take, done, busy, rx_byte);
  modport eng (input serial_port_on, master_role_select, clock_phase, clock_polarity,
               wired_or_output, lsb_first_select, start, tx_byte,
               output take, done, busy, rx_byte);
endinterface

// File: core/spc_engine.sv
`timescale 1ns/1ps
module spc_engine
  import spc_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  spc_link_if.eng lnk,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  output logic ss_n_o,
  output logic ss_n_oe_n_o,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  output logic miso_o,
  output logic miso_oe_n_o
);
  localparam int DW = $clog2(HALF_CYC + 1);
  localparam logic [DW-1:0] DIV_END = DW'(HALF_CYC - 1);
  wire on = lnk.serial_port_on;
  wire mst = lnk.master_role_select;
  wire cpha = lnk.clock_phase;
  wire cpol = lnk.clock_polarity;
  wire lsb = lnk.lsb_first_select;
  wire wom = lnk.wired_or_output;
  logic [3:0] sy1, sy2, sy3, filt;
  spc_state_e state;
  logic half, dbit, lvl_prev, ss_prev_n, take, done;
  logic [2:0] bitn;
  logic [7:0] txsh, rxsh, rx_byte;
  logic [DW-1:0] div;

  // ********
  // Pin synchronisers
  // ********
  // Order {miso, mosi, ss_n, sclk}; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sy1 <= 4'h2;
      sy2 <= 4'h2;
      sy3 <= 4'h2;
      filt <= 4'h2;
    end else begin
      sy1 <= {miso_i, mosi_i, ss_n_i, sclk_i};
      sy2 <= sy1;
      sy3 <= sy2;
      filt <= (sy2 & sy3) | (filt & (sy2 | sy3));
    end
  end
  wire ss_f_n = filt[1];
  wire in_bit = mst ? filt[3] : filt[2];
  wire lvl = filt[0] ^ cpol;
  wire smp_edge = cpha ? (~lvl & lvl_prev) : (lvl & ~lvl_prev);
  wire drv_edge = cpha ? (lvl & ~lvl_prev) : (~lvl & lvl_prev);
  wire tick = mst && state != SPC_IDLE && div == DIV_END;
  wire [7:0] tx_next = spc_shift_out(txsh, lsb);
  wire [7:0] rx_next = spc_shift_in(rxsh, in_bit, lsb);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_prev <= 1'b0;
      ss_prev_n <= 1'b1;
      div <= '0;
    end else begin
      lvl_prev <= lvl;
      ss_prev_n <= ss_f_n;
      if (state == SPC_IDLE || !mst || div == DIV_END) begin
        div <= '0;
      end else begin
        div <= div + DW'(1);
      end
    end
  end

  // ********
  // Byte sequencer
  // ********
  // Master samples at the close of the second half: the input path lags by four cycles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SPC_IDLE;
      half <= 1'b0;
      bitn <= 3'd0;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      dbit <= 1'b0;
      take <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      take <= 1'b0;
      done <= 1'b0;
      if (!on) begin
        state <= SPC_IDLE;
      end else if (mst) begin
        case (state)
          SPC_IDLE: if (lnk.start) begin
            state <= SPC_RUN;
            half <= 1'b0;
            bitn <= 3'd0;
            txsh <= lnk.tx_byte;
            dbit <= spc_out_bit(lnk.tx_byte, lsb);
            take <= 1'b1;
          end
          SPC_RUN: if (tick) begin
            half <= ~half;
            if (half) begin
              rxsh <= rx_next;
              if (bitn == 3'(XFER_BITS - 1)) begin
                state <= SPC_GAP;
              end else begin
                bitn <= bitn + 3'd1;
                txsh <= tx_next;
                dbit <= spc_out_bit(tx_next, lsb);
              end
            end
          end
          SPC_GAP: if (tick) begin
            state <= SPC_IDLE;
            done <= 1'b1;
            rx_byte <= rxsh;
          end
          default: state <= SPC_IDLE;
        endcase
      end else begin
        case (state)
          SPC_IDLE: if (!ss_f_n && ss_prev_n) begin
            state <= SPC_RUN;
            bitn <= 3'd0;
            txsh <= lnk.tx_byte;
            dbit <= spc_out_bit(lnk.tx_byte, lsb);
            take <= 1'b1;
          end
          SPC_RUN: if (ss_f_n) begin
            state <= SPC_IDLE;
          end else if (smp_edge) begin
            rxsh <= rx_next;
            bitn <= bitn + 3'd1;
            if (bitn == 3'(XFER_BITS - 1)) begin
              state <= SPC_IDLE;
              done <= 1'b1;
              rx_byte <= rx_next;
            end
          end else if (drv_edge && (!cpha || bitn != 3'd0)) begin
            txsh <= tx_next;
            dbit <= spc_out_bit(tx_next, lsb);
          end
          default: state <= SPC_IDLE;
        endcase
      end
    end
  end
  assign lnk.take = take;
  assign lnk.done = done;
  assign lnk.busy = state != SPC_IDLE;
  assign lnk.rx_byte = rx_byte;

  // ********
  // Pin drivers
  // ********
  wire mst_drv = on && mst;
  wire slv_drv = on && !mst && !ss_f_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_o <= 1'b0;
      sclk_oe_n_o <= 1'b1;
      ss_n_o <= 1'b1;
      ss_n_oe_n_o <= 1'b1;
      mosi_o <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      sclk_oe_n_o <= !mst;
      ss_n_oe_n_o <= !mst;
      sclk_o <= cpol ^ (mst_drv && state == SPC_RUN && (cpha ? !half : half));
      ss_n_o <= !(mst_drv && state != SPC_IDLE);
      mosi_o <= dbit && !wom;
      mosi_oe_n_o <= !(mst_drv && (!wom || !dbit));
      miso_o <= dbit && !wom;
      miso_oe_n_o <= !(slv_drv && (!wom || !dbit));
    end
  end

  // ********
  // Checks
  // ********
  logic [4:0] edges;
  logic sclk_prev;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edges <= 5'h00;
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_o;
      edges <= ss_n_o ? 5'h00 : edges + 5'(sclk_o != sclk_prev);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i || !on);
  a_byte_edges: assert property (mst && $rose(ss_n_o) |-> edges == 5'h10)
    else $error("select released after wrong number of clock edges");
  a_idle_level: assert property ($past(state) == SPC_IDLE |-> sclk_o == $past(cpol))
    else $error("serial clock not at idle level");
  a_clock_phase: assert property (mst && $fell(ss_n_o) |-> (sclk_o != cpol) == cpha)
    else $error("first clock half does not follow phase setting");
  a_open_drain: assert property ($past(wom) |-> !mosi_o && !miso_o)
    else $error("data pin driven high in wired-or mode");
  a_slave_pins: assert property (!$past(mst) |-> sclk_oe_n_o && ss_n_oe_n_o)
    else $error("slave drives clock or select");
endmodule

// File: core/spc_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Empty transmit FIFO without zero fill re-sends the last transmitted byte.
// - Empty transmit FIFO with zero fill sends an all-zero byte.
// - Trigger bit 6 set: in master mode a transmit data write requests a transfer.
// - Write-triggered mode interrupts only when the transmit FIFO becomes empty.
// - Trigger bit 6 clear: in master mode a receive data read requests a transfer.
// - Read-triggered mode interrupts only when the receive FIFO becomes full.
// - Bit 5 set shifts least significant bit first, clear most significant first.
// - Bit 4 set makes data outputs open drain, clear push-pull.
// - Bit 3 sets serial clock idle high when set, low when clear.
// - Bit 2 set pulses clock at bit start, clear at bit end.
// - Bit 1 set makes the port master driving clock and select, else slave.
// - Bit 0 switches the port on when set, off when clear.
// - Every transfer moves eight bits; master holds select for the whole byte.
module spc_port
  import spc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_N_O,
  input wire logic SS_N_I,
  output logic SS_N_O,
  output logic SS_N_OE_N_O,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_N_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_N_O
);
  // Depth must be a power of two so that the pointers wrap by themselves
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

  spc_link_if lnk();
  logic [15:0] ctrl;
  logic [IRQ_W-1:0] irq_st, irq_mask, next_irq_st;
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CW-1:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
  logic [7:0] last_sent;
  logic start_req, rx_rd_ok;
  logic [31:0] rdata;

  // ********
  // Bus decode
  // ********
  wire setup = PSEL_I && !PENABLE_I;
  wire access = PSEL_I && PENABLE_I && PREADY_O;
  wire wr = access && PWRITE_I;
  wire rd = access && !PWRITE_I;
  wire hit_ctrl = PADDR_I == OFS_CTRL;
  wire hit_tx = PADDR_I == OFS_TXDATA;
  wire hit_rx = PADDR_I == OFS_RXDATA;
  wire hit_ist = PADDR_I == OFS_IRQ_ST;
  wire hit_msk = PADDR_I == OFS_IRQ_MASK;

  // ********
  // Control register
  // ********
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl <= CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl <= PWDATA_I[15:0] & CTRL_IMPL;
    end
  end
  wire port_on = ctrl[B_SERIAL_PORT_ON];
  wire mst = ctrl[B_MASTER_ROLE];
  wire tmode = ctrl[B_TRIGGER_MODE];
  wire zfill = ctrl[B_ZERO_FILL];
  assign lnk.serial_port_on = port_on;
  assign lnk.master_role_select = mst;
  assign lnk.clock_phase = ctrl[B_CLOCK_PHASE];
  assign lnk.clock_polarity = ctrl[B_CLOCK_POLARITY];
  assign lnk.wired_or_output = ctrl[B_WIRED_OR];
  assign lnk.lsb_first_select = ctrl[B_LSB_FIRST];

  // ********
  // Transmit FIFO
  // ********
  wire tx_push = wr && hit_tx && tx_cnt != FULL_CNT;
  wire tx_pop = lnk.take && tx_cnt != '0;
  assign next_tx_cnt = tx_cnt + CW'(tx_push) - CW'(tx_pop);

  always_ff @(posedge CLK_SYS_I) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_wp <= tx_wp + PW'(1);
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + PW'(1);
      end
      tx_cnt <= next_tx_cnt;
    end
  end

  // Whatever the engine takes becomes the byte to repeat later
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_sent <= 8'h00;
    end else if (lnk.take) begin
      last_sent <= lnk.tx_byte;
    end
  end
  assign lnk.tx_byte = (tx_cnt != '0) ? tx_mem[tx_rp]
                     : (zfill ? 8'h00 : last_sent);

  // ********
  // Receive FIFO
  // ********
  // A byte that arrives while full is dropped, the stored ones are kept
  wire rx_push = lnk.done && rx_cnt != FULL_CNT;
  wire rx_pop = rd && hit_rx && rx_rd_ok;
  assign next_rx_cnt = rx_cnt + CW'(rx_push) - CW'(rx_pop);

  always_ff @(posedge CLK_SYS_I) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= lnk.rx_byte;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) begin
        rx_wp <= rx_wp + PW'(1);
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + PW'(1);
      end
      rx_cnt <= next_rx_cnt;
    end
  end

  // ********
  // Transfer start
  // ********
  wire trig = tmode ? (wr && hit_tx) : (rd && hit_rx);
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      start_req <= 1'b0;
    end else if (!port_on || !mst) begin
      start_req <= 1'b0;
    end else if (trig) begin
      start_req <= 1'b1;
    end else if (lnk.take) begin
      start_req <= 1'b0;
    end
  end
  assign lnk.start = start_req;

  // ********
  // Interrupts
  // ********
  wire ev_txe = port_on && tmode && tx_cnt != '0 && next_tx_cnt == '0;
  wire ev_rxf = port_on && !tmode && rx_cnt != FULL_CNT && next_rx_cnt == FULL_CNT;
  wire [IRQ_W-1:0] ev = {ev_rxf, ev_txe};
  wire [IRQ_W-1:0] clr = (wr && hit_ist) ? PWDATA_I[IRQ_W-1:0] : '0;
  assign next_irq_st = (irq_st & ~clr) | ev;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_st <= IRQ_RST;
      irq_mask <= IRQ_RST;
      IRQ_O <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      if (wr && hit_msk) begin
        irq_mask <= PWDATA_I[IRQ_W-1:0];
      end
      IRQ_O <= |(irq_st & irq_mask);
    end
  end

  // ********
  // Read path and bus answer
  // ********
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata[15:0] = ctrl;
    end else if (hit_rx) begin
      rdata[7:0] = (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00;
    end else if (PADDR_I == OFS_STATUS) begin
      rdata[ST_TXCNT +: CW] = tx_cnt;
      rdata[ST_RXCNT +: CW] = rx_cnt;
      rdata[ST_BUSY] = lnk.busy;
      rdata[ST_PEND] = start_req;
    end else if (hit_ist) begin
      rdata[IRQ_W-1:0] = irq_st;
    end else if (hit_msk) begin
      rdata[IRQ_W-1:0] = irq_mask;
    end
  end

  // Read data is caught in the setup cycle, so the pop only follows a byte really shown
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      rx_rd_ok <= 1'b0;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup && !spc_mapped(PADDR_I);
      if (setup) begin
        PRDATA_O <= rdata;
        rx_rd_ok <= rx_cnt != '0;
      end
    end
  end

  // ********
  // Serial engine
  // ********
  spc_engine #(
    .HALF_CYC(SCLK_HALF_CYC)
  ) u_engine (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .lnk(lnk.eng),
    .sclk_i(SCLK_I),
    .ss_n_i(SS_N_I),
    .mosi_i(MOSI_I),
    .miso_i(MISO_I),
    .sclk_o(SCLK_O),
    .sclk_oe_n_o(SCLK_OE_N_O),
    .ss_n_o(SS_N_O),
    .ss_n_oe_n_o(SS_N_OE_N_O),
    .mosi_o(MOSI_O),
    .mosi_oe_n_o(MOSI_OE_N_O),
    .miso_o(MISO_O),
    .miso_oe_n_o(MISO_OE_N_O)
  );

  // ********
  // Checks
  // ********
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence s_tx_write;
    wr && hit_tx;
  endsequence
  sequence s_rx_read;
    rd && hit_rx;
  endsequence
  sequence s_master_on;
    port_on && mst;
  endsequence
  a_write_start: assert property (s_tx_write ##0 s_master_on ##0 tmode |=> start_req)
    else $error("transmit write did not request a transfer");
  a_read_start: assert property (s_rx_read ##0 s_master_on ##0 !tmode |=> start_req)
    else $error("receive read did not request a transfer");
  a_start_taken: assert property (start_req && !lnk.busy ##1 s_master_on |-> lnk.take)
    else $error("pending transfer not started");
  a_repeat_last: assert property (lnk.take && tx_cnt == '0 && !zfill
                                  |=> last_sent == $past(last_sent))
    else $error("empty FIFO did not repeat the last byte");
  a_zero_fill: assert property (lnk.take && tx_cnt == '0 && zfill |=> last_sent == 8'h00)
    else $error("empty FIFO did not send zero");
  a_tx_irq_only: assert property ($rose(irq_st[I_TXE]) |-> $past(tmode) && tx_cnt == '0)
    else $error("transmit interrupt outside write-triggered mode");
  a_rx_irq_only: assert property ($rose(irq_st[I_RXF]) |-> !$past(tmode)
                                  && rx_cnt == FULL_CNT)
    else $error("receive interrupt outside read-triggered mode");
  a_off_quiet: assert property (!port_on ##1 !port_on |-> !lnk.take && !start_req
                                && (irq_st & ~$past(irq_st)) == '0)
    else $error("disabled port started a transfer or raised an event");
  a_apb_answer: assert property (setup ##1 PSEL_I && PENABLE_I
                                 |-> PREADY_O && PSLVERR_O == !spc_mapped(PADDR_I))
    else $error("bus answer missing or wrong error flag");
endmodule

// File: tb/spc_slave_model.sv
`timescale 1ns/1ps
module spc_slave_model (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] ctrl_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  int s;
  int d;
  logic lead;
  initial begin
    s = 0;
    d = 0;
    rx_o = 8'h00;
    miso_o = 1'b0;
  end
  // A released line shows the inverse, so a stale bit never passes
  always @(ss_n_i) begin
    s = 0;
    d = 0;
    miso_o = ss_n_i ? ~miso_o : (ctrl_i[5] ? tx_i[0] : tx_i[7]);
  end
  // Shift edge copies the sample count, so phase 1 keeps bit 0 on the first lead
  always @(sclk_i) begin
    lead = sclk_i != ctrl_i[3];
    if (!ss_n_i && lead != ctrl_i[2]) begin
      rx_o = ctrl_i[5] ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      s++;
    end else if (!ss_n_i) begin
      d = s;
      miso_o = ctrl_i[5] ? tx_i[d[2:0]] : tx_i[7 - d[2:0]];
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import spc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, irq, slverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sclk_o, sclk_oen, ss_o, ss_oen, mosi_o, mosi_oen, miso_o, miso_oen;
  logic drv, tsclk, tss, tmosi, sclk_q, ss_q, m_miso;
  logic [7:0] ctrl, ptx, mrx, got;
  logic [23:0] tab [6];
  int error_cnt, compares, edges, falls, bad;
  wire sclk_w = drv ? tsclk : sclk_o;
  wire ss_w = drv ? tss : ss_o;
  wire mosi_w = drv ? tmosi : (mosi_oen ? 1'b1 : mosi_o);
  wire miso_w = miso_oen ? m_miso : miso_o;
  spc_port #(.FIFO_DEPTH(4)) i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
    .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE_N_O(sclk_oen), .SS_N_I(ss_w),
    .SS_N_O(ss_o), .SS_N_OE_N_O(ss_oen), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE_N_O(mosi_oen), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N_O(miso_oen));
  spc_slave_model i_peer (.sclk_i(sclk_w), .ss_n_i(ss_w | drv), .mosi_i(mosi_w),
    .ctrl_i(ctrl), .tx_i(ptx), .miso_o(m_miso), .rx_o(mrx));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ********
  // Tasks
  // ********
  task chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    // Ready, error flag and read data are all taken at the edge that ends the access
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) error_cnt++;
    slverr = pslverr;
    rd = prdata;
    psel <= 0;
    pen <= 0;
  endtask
  task idle;
    int n;
    n = 0;
    do begin
      apb(0, OFS_STATUS, 0);
      n++;
    end while (rd[9:8] !== 2'b00 && n < 100);
    if (rd[9:8] !== 2'b00) error_cnt++;
  endtask
  task test_done;
    $display("Errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!ss_o && sclk_o !== sclk_q) edges++;
    if (ss_q && !ss_o) falls++;
    if (!ss_o && (ctrl[4] ? (!mosi_oen && mosi_o) : mosi_oen)) bad++;
    sclk_q = sclk_o;
    ss_q = ss_o;
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  // ********
  // Sequence
  // ********
  initial begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; drv = 0; tsclk = 0;
    tss = 1; tmosi = 0; ctrl = 0; ptx = 0; sclk_q = 0; ss_q = 1; got = 0;
    error_cnt = 0; compares = 0; edges = 0; falls = 0; bad = 0;
    tab = '{24'h43a53c, 24'h4796c1, 24'h4b5a0f, 24'h4f817e, 24'h630180, 24'h53c335};
    repeat (4) @(posedge clk);
    rst_n <= 1;
    apb(0, OFS_CTRL, 0);
    chk(rd, 0);
    chk({irq, ss_o, sclk_o}, 3'b010);
    apb(0, 8'h18, 0);
    chk({slverr, rd}, 33'h100000000);
    apb(1, OFS_CTRL, 32'hffffffff);
    apb(0, OFS_CTRL, 0);
    chk(rd, 32'h000000ff);
    apb(1, OFS_IRQ_MASK, 3);
    foreach (tab[i]) begin
      ctrl = tab[i][23:16];
      ptx = tab[i][7:0];
      apb(1, OFS_CTRL, ctrl);
      edges = 0;
      apb(1, OFS_TXDATA, tab[i][15:8]);
      idle;
      chk(mrx, tab[i][15:8]);
      chk(edges, 16);
      chk(falls, i + 1);
      chk(sclk_o, ctrl[3]);
      apb(0, OFS_RXDATA, 0);
      chk(rd, ptx);
    end
    chk(bad, 0);
    ctrl = 8'h03;
    apb(1, OFS_CTRL, ctrl);
    apb(0, OFS_RXDATA, 0);
    idle;
    chk(mrx, 8'hc3);
    ctrl = 8'h83;
    apb(1, OFS_CTRL, ctrl);
    apb(0, OFS_RXDATA, 0);
    idle;
    chk(mrx, 8'h00);
    ctrl = 8'h43;
    apb(1, OFS_CTRL, ctrl);
    apb(0, OFS_RXDATA, 0);
    apb(1, OFS_IRQ_ST, 3);
    for (int k = 0; k < 4; k++) begin
      apb(1, OFS_TXDATA, k);
      idle;
    end
    apb(0, OFS_IRQ_ST, 0);
    chk({irq, rd}, 33'h100000001);
    apb(1, OFS_IRQ_ST, 1);
    apb(0, OFS_IRQ_ST, 0);
    chk({irq, rd}, 33'h0);
    ctrl = 8'h03;
    apb(1, OFS_CTRL, ctrl);
    apb(0, OFS_RXDATA, 0);
    idle;
    apb(0, OFS_IRQ_ST, 0);
    chk({irq, rd}, 33'h100000002);
    apb(1, OFS_IRQ_MASK, 1);
    apb(0, OFS_IRQ_ST, 0);
    chk(irq, 0);
    ctrl = 8'h41;
    apb(1, OFS_CTRL, ctrl);
    repeat (4) apb(0, OFS_RXDATA, 0);
    chk({sclk_oen, ss_oen}, 2'b11);
    apb(1, OFS_TXDATA, 8'h6c);
    ptx = 8'h93;
    drv <= 1;
    tss <= 0;
    repeat (4) @(posedge clk);
    for (int b = 7; b >= 0; b--) begin
      tmosi <= ptx[b];
      repeat (4) @(posedge clk);
      tsclk <= 1;
      repeat (4) @(posedge clk);
      // The slave's pin path lags several cycles, so the bit is taken late in the high half
      got[b] = miso_w;
      tsclk <= 0;
    end
    repeat (4) @(posedge clk);
    tss <= 1;
    chk(got, 8'h6c);
    apb(0, OFS_RXDATA, 0);
    chk(rd, 8'h93);
    drv <= 0;
    apb(1, OFS_IRQ_ST, 3);
    ctrl = 8'h4a;
    apb(1, OFS_CTRL, ctrl);
    apb(1, OFS_TXDATA, 8'h11);
    repeat (100) @(posedge clk);
    chk({falls, sclk_o, mosi_oen}, {32'd13, 2'b11});
    apb(0, OFS_IRQ_ST, 0);
    chk(rd, 0);
    test_done;
  end
endmodule
